// file: logic/pspe_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module pspe_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule : pspe_fifo

// file: logic/pspe_pkg.sv
// shared constants for the port e parallel slave block
package pspe_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_DIR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PIN_LEVELS = 8'h04;
  localparam logic [7:0] ADDR_OUT_LATCH  = 8'h08;
  localparam logic [7:0] ADDR_SLAVE_DATA = 8'h0C;
  localparam logic [7:0] ADDR_ANALOG_CFG = 8'h10;
  localparam logic [7:0] ADDR_EVENT      = 8'h14;
  localparam logic [7:0] ADDR_RX_FIFO    = 8'h18;
  // direction and status fields
  localparam int unsigned BIT_IBF   = 7;
  localparam int unsigned BIT_OBF   = 6;
  localparam int unsigned BIT_INPUT_OVERFLOW  = 5;
  localparam int unsigned BIT_MODE  = 4;
  localparam int unsigned BIT_RD_N  = 0;
  localparam int unsigned BIT_WR_N  = 1;
  localparam int unsigned BIT_CS_N  = 2;
  // event register fields
  localparam int unsigned BIT_EV_FLAG = 0;
  localparam int unsigned BIT_EV_EN   = 1;
  // analog config: pins digital when all three bits set
  localparam logic [2:0] ANALOG_ALL_DIGITAL = 3'h7;
  localparam logic [2:0] DIR_RESET    = 3'h7;
  localparam logic [2:0] ANALOG_RESET = 3'h0;
endpackage : pspe_pkg

// file: logic/pspe_sync.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pspe_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic        INIT  = 1'b1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= {WIDTH{INIT}};
      q    <= {WIDTH{INIT}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pspe_sync

// file: logic/pspe_top.sv
// port e pins with parallel slave port, apb register slave
//
// Behaviour
// [RULE_01] three pins, direction bit one means input and high impedance, zero drives latch
// [RULE_02] output latch register reads back latched values, not pin levels
// [RULE_03] pins selected as analog read as zero in the pin level register
// [RULE_04] direction bits steer drivers even when pins are analog
// [RULE_05] reset leaves pins analog with direction bits set to input
// [RULE_06] input buffer full reads one while an external byte awaits the cpu
// [RULE_07] output buffer full set by cpu write, cleared once external side reads
// [RULE_08] overflow sets on external write before cpu read; software clears it
// [RULE_09] slave mode select at bit four of direction and status register
// [RULE_10] in slave mode the data port is a byte port for the external processor
// [RULE_11] slave mode uses pin 0 as read, pin 1 as write, pin 2 as select, all low
// [RULE_12] firmware must set pins to input and digital before using slave mode
// [RULE_13] external write registered when select and write first seen low together
// [RULE_14] external read registered when select and read first seen low together
// [RULE_15] the external processor sees the data port as one byte latch
// [RULE_16] write low with select captures the external bus byte
// [RULE_17] read low with select drives the data register onto the external bus
// [RULE_18] chip select is active low; high deselects the port
// [RULE_19] event flag with enable raised on each completed external transfer
`timescale 1ns/1ps
module pspe_top #(
  parameter int unsigned FIFO_DEPTH = pspe_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port e pins
  input  wire logic [2:0]  pin_e_in,
  output logic      [2:0]  pin_e_out,
  output logic      [2:0]  pin_e_oe,
  // data port byte towards the external processor
  input  wire logic [7:0]  data_bus_in,
  output logic      [7:0]  data_bus_out,
  output logic             data_bus_oe,
  // cpu event line
  output logic             slave_port_event
);
  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("fifo depth below 2 cannot buffer");
  end

  typedef enum logic [2:0] {
    PSPE_IDLE  = 3'b001,
    PSPE_WRITE = 3'b010,
    PSPE_READ  = 3'b100
  } pspe_state_t;

  // registers
  logic [2:0]  dir_bits;
  logic        slave_mode_select;
  logic        input_buffer_full;
  logic        output_buffer_full;
  logic        input_overflow;
  logic [2:0]  out_latch;
  logic [2:0]  analog_pin_config;
  logic [7:0]  slave_data_byte;
  logic        slave_port_event_flag;
  logic        slave_port_event_enable;
  pspe_state_t state;

  // synchronised pins and data
  logic [2:0]  pin_sync;
  logic [7:0]  data_sync;
  logic        pins_digital;
  logic        sel_rd;
  logic        sel_wr;

  // apb and external transfer decode
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        ext_wr_start;
  logic        ext_rd_start;
  logic        ext_done;

  // fifo
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;

  // pins cross from outside the clock domain
  pspe_sync #(.WIDTH(3), .INIT(1'b1)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_e_in),
    .q       (pin_sync)
  );

  pspe_sync #(.WIDTH(8), .INIT(1'b0)) u_data_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (data_bus_in),
    .q       (data_sync)
  );

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction : addr_is

  assign acc    = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;

  // strobe decode only trusted when firmware has pins digital, whatever the direction bits
  assign pins_digital = (analog_pin_config == pspe_pkg::ANALOG_ALL_DIGITAL); // [RULE_12]
  // select is active low, strobes qualified by it
  assign sel_rd = slave_mode_select && pins_digital && !pin_sync[pspe_pkg::BIT_CS_N]
                  && !pin_sync[pspe_pkg::BIT_RD_N]; // [RULE_11] [RULE_18]
  assign sel_wr = slave_mode_select && pins_digital && !pin_sync[pspe_pkg::BIT_CS_N]
                  && !pin_sync[pspe_pkg::BIT_WR_N]; // [RULE_11] [RULE_18]

  // first detection opens a transfer; completion is strobe release
  assign ext_wr_start = (state == PSPE_IDLE) && sel_wr; // [RULE_13]
  assign ext_rd_start = (state == PSPE_IDLE) && sel_rd && !sel_wr; // [RULE_14]
  assign ext_done     = ((state == PSPE_WRITE) && !sel_wr) || ((state == PSPE_READ) && !sel_rd);

  // a cpu read of the receive fifo register takes a received byte from the fifo
  assign fifo_pop = rd_acc && addr_is(paddr, pspe_pkg::ADDR_RX_FIFO) && fifo_out_valid;

  // received bytes queue here so the cpu can drain a burst
  pspe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (ext_wr_start),
    .in_ready  (fifo_in_ready),
    .in_data   (data_sync),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // transfer state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= PSPE_IDLE;
    else
    begin
      case (state)
        PSPE_IDLE:
        begin
          if (ext_wr_start)
            state <= PSPE_WRITE;
          else if (ext_rd_start)
            state <= PSPE_READ;
        end
        PSPE_WRITE:
        begin
          if (!sel_wr)
            state <= PSPE_IDLE;
        end
        PSPE_READ:
        begin
          if (!sel_rd)
            state <= PSPE_IDLE;
        end
        default:
          state <= PSPE_IDLE;
      endcase
    end
  end

  // direction, mode, latch and analog configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_bits          <= pspe_pkg::DIR_RESET; // [RULE_05]
      analog_pin_config <= pspe_pkg::ANALOG_RESET; // [RULE_05]
      slave_mode_select <= 1'b0;
      out_latch         <= 3'h0;
      slave_port_event_enable <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (addr_is(paddr, pspe_pkg::ADDR_DIR_STATUS))
      begin
        dir_bits          <= pwdata[2:0]; // [RULE_01]
        slave_mode_select <= pwdata[pspe_pkg::BIT_MODE]; // [RULE_09]
      end
      else if (addr_is(paddr, pspe_pkg::ADDR_OUT_LATCH) || addr_is(paddr, pspe_pkg::ADDR_PIN_LEVELS))
        out_latch <= pwdata[2:0];
      else if (addr_is(paddr, pspe_pkg::ADDR_ANALOG_CFG))
        analog_pin_config <= pwdata[2:0];
      else if (addr_is(paddr, pspe_pkg::ADDR_EVENT))
        slave_port_event_enable <= pwdata[pspe_pkg::BIT_EV_EN];
    end
  end

  // the one byte latch both sides see
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slave_data_byte <= 8'h00;
    else if (ext_wr_start)
      slave_data_byte <= data_sync; // [RULE_15] [RULE_16]
    else if (wr_acc && addr_is(paddr, pspe_pkg::ADDR_SLAVE_DATA))
      slave_data_byte <= pwdata[7:0];
  end

  // input buffer full is the fifo holding a byte; its valid is already a flop-fed
  // occupancy test, so no peek into the fifo's counter is needed
  assign input_buffer_full = fifo_out_valid; // [RULE_06]

  // output buffer full: external read start clears it, cpu write wins on a tie
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      output_buffer_full <= 1'b0;
    else if (wr_acc && addr_is(paddr, pspe_pkg::ADDR_SLAVE_DATA))
      output_buffer_full <= 1'b1; // [RULE_07]
    else if (ext_rd_start)
      output_buffer_full <= 1'b0; // [RULE_07]
  end

  // overflow: the set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      input_overflow <= 1'b0;
    else if (ext_wr_start && (input_buffer_full || !fifo_in_ready))
      input_overflow <= 1'b1; // [RULE_08]
    else if (wr_acc && addr_is(paddr, pspe_pkg::ADDR_DIR_STATUS) && !pwdata[pspe_pkg::BIT_INPUT_OVERFLOW])
      input_overflow <= 1'b0; // [RULE_08]
  end

  // event flag on each completed transfer; set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slave_port_event_flag <= 1'b0;
    else if (ext_done)
      slave_port_event_flag <= 1'b1; // [RULE_19]
    else if (wr_acc && addr_is(paddr, pspe_pkg::ADDR_EVENT) && pwdata[pspe_pkg::BIT_EV_FLAG])
      slave_port_event_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slave_port_event <= 1'b0;
    else
      slave_port_event <= (slave_port_event_flag || ext_done) && slave_port_event_enable; // [RULE_19]
  end

  // pin drivers follow direction bits even in analog or slave mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_e_oe  <= 3'h0;
      pin_e_out <= 3'h0;
    end
    else
    begin
      pin_e_oe  <= ~dir_bits; // [RULE_01] [RULE_04]
      pin_e_out <= out_latch; // [RULE_01]
    end
  end

  // data bus driven only while selected and read strobe low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_bus_oe  <= 1'b0;
      data_bus_out <= 8'h00;
    end
    else
    begin
      data_bus_oe  <= sel_rd && !sel_wr; // [RULE_10] [RULE_17]
      data_bus_out <= slave_data_byte; // [RULE_17]
    end
  end

  // apb answers in the access cycle; unmapped addresses error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (addr_is(paddr, pspe_pkg::ADDR_DIR_STATUS))
          prdata[7:0] <= {input_buffer_full, output_buffer_full, input_overflow, slave_mode_select,
                          1'b0, dir_bits}; // [RULE_06] [RULE_09]
        else if (addr_is(paddr, pspe_pkg::ADDR_PIN_LEVELS))
          prdata[2:0] <= pins_digital ? pin_sync : 3'h0; // [RULE_03]
        else if (addr_is(paddr, pspe_pkg::ADDR_OUT_LATCH))
          prdata[2:0] <= out_latch; // [RULE_02]
        else if (addr_is(paddr, pspe_pkg::ADDR_SLAVE_DATA))
          prdata[7:0] <= slave_data_byte; // [RULE_15]
        else if (addr_is(paddr, pspe_pkg::ADDR_ANALOG_CFG))
          prdata[2:0] <= analog_pin_config;
        else if (addr_is(paddr, pspe_pkg::ADDR_EVENT))
          prdata[1:0] <= {slave_port_event_enable, slave_port_event_flag};
        else if (addr_is(paddr, pspe_pkg::ADDR_RX_FIFO))
          prdata[8:0] <= {fifo_out_valid, fifo_out_data};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule : pspe_top

// file: verif/pspe_ext_host.sv
// external byte-bus processor model facing the slave port
`timescale 1ns/1ps
module pspe_ext_host (
  // clock
  input wire logic       pclk,
  // strobes: bit0 read, bit1 write, bit2 select, low active
  output logic     [2:0] strobe_n,
  // data bus
  output logic     [7:0] bus_drive,
  input wire logic [7:0] bus_seen
);
  initial
  begin
    strobe_n  = 3'h7;
    bus_drive = 8'h00;
  end
  // hold sets a prompt or slow transfer
  task automatic xfer(input logic [2:0] low, input logic [7:0] wd, input int hold, output logic [7:0] rdat);
    begin
      bus_drive <= wd;
      // data settles before the strobe falls
      repeat (3) @(posedge pclk);
      strobe_n <= low;
      repeat (hold) @(posedge pclk);
      rdat = bus_seen;
      strobe_n <= 3'h7;
      // released bus must not look like the last byte
      bus_drive <= ~wd;
      repeat (4) @(posedge pclk);
    end
  endtask : xfer
endmodule : pspe_ext_host

// file: verif/pspe_props.sv
// assertion checker for the port e slave block
`timescale 1ns/1ps
module pspe_props (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [2:0]  pin_e_in,
  input wire logic [2:0]  pin_e_out,
  input wire logic [2:0]  pin_e_oe,
  input wire logic [7:0]  data_bus_in,
  input wire logic [7:0]  data_bus_out,
  input wire logic        data_bus_oe,
  input wire logic        slave_port_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  a_reset_idle: assert property ($rose(presetn) |-> pin_e_oe == 3'h0 && !data_bus_oe)
    else $error("drivers on after reset");
  a_dir_cause: assert property ($changed(pin_e_oe) |-> $past(pready && pwrite, 2))
    else $error("pin drivers changed without write");
  a_latch_cause: assert property ($changed(pin_e_out) |-> $past(pready && pwrite, 2))
    else $error("latch changed without write");
  // two synchroniser stages plus the output flop put the cause three samples back
  a_bus_oe_cause: assert property ($rose(data_bus_oe) |-> !$past(pin_e_in[2], 3) &&
    !$past(pin_e_in[0], 3))
    else $error("bus driven without select and read");
  a_bus_oe_end: assert property (data_bus_oe && pin_e_in[0] |-> ##[1:4] !data_bus_oe)
    else $error("bus still driven after read");
  a_idle_select: assert property (pin_e_in[2] [*5] |-> !data_bus_oe)
    else $error("bus driven while deselected");
endmodule : pspe_props

bind pspe_top pspe_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .pin_e_in, .pin_e_out, .pin_e_oe, .data_bus_in,
  .data_bus_out, .data_bus_oe, .slave_port_event);

// file: verif/tb.sv
// self-checking bench for the port e slave block
`timescale 1ns/1ps
module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pin_e_in;
  logic [2:0]  pin_e_out;
  logic [2:0]  pin_e_oe;
  logic [2:0]  host_n;
  logic [7:0]  data_bus_in;
  logic [7:0]  data_bus_out;
  logic        data_bus_oe;
  logic [7:0]  host_d;
  logic        slave_port_event;
  logic [31:0] rd;
  logic        se;
  logic [7:0]  hb;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  // wire level: device where it drives, host elsewhere
  assign pin_e_in    = (pin_e_oe & pin_e_out) | (~pin_e_oe & host_n);
  assign data_bus_in = data_bus_oe ? data_bus_out : host_d;

  pspe_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_e_in, .pin_e_out, .pin_e_oe, .data_bus_in, .data_bus_out, .data_bus_oe,
    .slave_port_event);
  pspe_ext_host u_host (.pclk, .strobe_n(host_n), .bus_drive(host_d), .bus_seen(data_bus_in));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      checks_done++;
      if (got !== exp)
      begin
        err_total++;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50)
        chk("pready", 1, pready);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  task automatic t_reset();
    rchk("dir", pspe_pkg::ADDR_DIR_STATUS, 32'h07);
    rchk("analog", pspe_pkg::ADDR_ANALOG_CFG, 32'h0);
    rchk("pins", pspe_pkg::ADDR_PIN_LEVELS, 32'h0);
    chk("oe", 32'h0, pin_e_oe);
    $display("reset test done");
  endtask : t_reset

  task automatic t_gpio();
    apb(1'b1, pspe_pkg::ADDR_OUT_LATCH, 32'h05);
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h00);
    rchk("pins", pspe_pkg::ADDR_PIN_LEVELS, 32'h0);
    chk("oe", 32'h7, pin_e_oe);
    chk("out", 32'h5, pin_e_out);
    apb(1'b1, pspe_pkg::ADDR_ANALOG_CFG, 32'h7);
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h05);
    repeat (3) @(posedge pclk);
    rchk("pins", pspe_pkg::ADDR_PIN_LEVELS, 32'h5);
    rchk("latch", pspe_pkg::ADDR_OUT_LATCH, 32'h5);
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h07);
    apb(1'b0, 8'h1C, 32'h0);
    chk("err", 32'h1, se);
    $display("port test done");
  endtask : t_gpio

  task automatic t_rx();
    int i;
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h17);
    apb(1'b1, pspe_pkg::ADDR_EVENT, 32'h02);
    u_host.xfer(3'b001, 8'hA5, 4, hb);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h97);
    chk("event", 32'h1, slave_port_event);
    rchk("fifo", pspe_pkg::ADDR_RX_FIFO, 32'h1A5);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h17);
    // nine bytes into eight places, slow and prompt strobes mixed
    for (i = 0; i < 9; i++)
      u_host.xfer(3'b001, 8'h10 + 8'(i), (i % 2) ? 7 : 3, hb);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'hB7);
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h17);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h97);
    for (i = 0; i < 8; i++)
      rchk("fifo", pspe_pkg::ADDR_RX_FIFO, 32'h110 + i);
    apb(1'b0, pspe_pkg::ADDR_RX_FIFO, 32'h0);
    chk("empty", 32'h0, rd[8]);
    $display("receive test done");
  endtask : t_rx

  task automatic t_tx();
    apb(1'b1, pspe_pkg::ADDR_SLAVE_DATA, 32'h3C);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h57);
    u_host.xfer(3'b010, 8'h00, 6, hb);
    chk("host", 32'h3C, hb);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h17);
    apb(1'b1, pspe_pkg::ADDR_EVENT, 32'h03);
    repeat (2) @(posedge pclk);
    chk("event", 32'h0, slave_port_event);
    u_host.xfer(3'b101, 8'h77, 4, hb);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h17);
    chk("event", 32'h0, slave_port_event);
    apb(1'b1, pspe_pkg::ADDR_DIR_STATUS, 32'h07);
    u_host.xfer(3'b001, 8'h66, 4, hb);
    rchk("status", pspe_pkg::ADDR_DIR_STATUS, 32'h07);
    $display("transmit test done");
  endtask : t_tx

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gpio();
    t_rx();
    t_tx();
    report_and_stop();
  end
endmodule : tb
